// ==== common/steer_pkg.sv ====
// Shared constants and types for the port steering transmit buffer
//
// Notes on behaviour
// - Condensed style carries all I/O on one transmit and one receive stream channel.
// - Initiator/target style: own requests and their responses on initiator, others on target.
// - I/O port uses header-encoded or raw stream format, header-encoded is default.
// - User-defined port always uses raw stream format.
// - Messages combined with I/O travel like an I/O write.
// - Separate messaging port has its own initiator/target pair, or merges onto user port.
// - Separate messaging port picks its format; shared messages follow the host port.
// - Without maintenance sourcing, no user maintenance port; configuration master still used.
// - Maintenance goes to lite port, direct stream port, or user port if enabled.
// - Transmit and receive buffers hold 8, 16 or 32 packets, chosen independently.
// - Reordering on: higher-priority waiting requests leave before lower-priority ones.
// - Reordering off: requests leave strictly in acceptance order.
// - Responses always leave before waiting requests.
// - Unified clock: both layer clocks share one source, no crossing logic.
// - Transmitter flow control tried first, receiver flow control if partner lacks it.
// - Receiver flow control sends regardless of partner buffers, retry regulates flow.
// - Transmitter flow control sends a priority only above its watermark.
// - Priority 3 may be sent until partner free count reaches zero.
// - High, medium, lowest watermarks gate priorities 2, 1 and 0.
package steer_pkg;

    localparam int APB_ADDR_W = 8;

    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] WMARK_OFFSET    = 8'h04;
    localparam logic [7:0] STATUS_OFFSET   = 8'h08;
    localparam logic [7:0] CAPACITY_OFFSET = 8'h0C;

    // Control register fields
    localparam int REORDER_BIT     = 0;
    localparam int TXFC_BIT        = 1;
    localparam int IO_INITTARG_BIT = 2;
    localparam int IO_RAW_BIT      = 3;
    localparam int MSG_STYLE_LSB   = 4;
    localparam int MSG_RAW_BIT     = 6;
    localparam int MAINT_STYLE_LSB = 8;
    localparam int MAINT_RAW_BIT   = 10;
    localparam int USER_EN_BIT     = 11;
    localparam int SRC_MAINT_BIT   = 12;
    localparam int UNIFIED_BIT     = 13;
    localparam logic [31:0] CTRL_RESET = 32'h0000_3807;

    // Watermark register fields
    localparam int WM_W        = 8;
    localparam int WM_HIGH_LSB = 0;
    localparam int WM_MED_LSB  = 8;
    localparam int WM_LOW_LSB  = 16;
    localparam logic [31:0] WMARK_RESET = 32'h0003_0201;

    // Status and capacity register fields
    localparam int FC_STATE_LSB  = 0;
    localparam int OCC_LSB       = 8;
    localparam int FREE_LSB      = 16;
    localparam int STAT_UNIF_BIT = 24;
    localparam int TX_CAP_LSB    = 0;
    localparam int RX_CAP_LSB    = 8;

    localparam int FREE_W = 8;

    typedef enum logic [1:0] {
        FC_INIT        = 2'b00,
        FC_TRANSMITTER = 2'b01,
        FC_RECEIVER    = 2'b11
    } fc_state_e;

    typedef enum logic [1:0] {
        MSG_WITH_IO   = 2'b00,
        MSG_SEPARATE  = 2'b01,
        MSG_WITH_USER = 2'b10
    } msg_style_e;

    typedef enum logic [1:0] {
        MAINT_LITE      = 2'b00,
        MAINT_STREAM    = 2'b01,
        MAINT_WITH_USER = 2'b10
    } maint_style_e;

    typedef enum logic [2:0] {
        CLASS_IO_REQ  = 3'h0,
        CLASS_IO_RESP = 3'h1,
        CLASS_MSG     = 3'h2,
        CLASS_MAINT   = 3'h3,
        CLASS_USER    = 3'h4
    } pkt_class_e;

    typedef enum logic [3:0] {
        PORT_NONE         = 4'h0,
        PORT_IO_TX        = 4'h1,
        PORT_IO_RX        = 4'h2,
        PORT_INITIATOR    = 4'h3,
        PORT_TARGET       = 4'h4,
        PORT_MSG_INIT     = 4'h5,
        PORT_MSG_TARG     = 4'h6,
        PORT_MAINT_LITE   = 4'h7,
        PORT_MAINT_STREAM = 4'h8,
        PORT_USER         = 4'h9,
        PORT_CFG_MASTER   = 4'hA
    } port_sel_e;

    localparam logic [2:0] RANK_RESPONSE = 3'h4;

endpackage

// ==== logic/fc_gate.sv ====
// Watermark gate deciding whether a packet priority may start now
`timescale 1ns/10ps
`default_nettype none
module fc_gate (
    input  wire steer_pkg::fc_state_e                 fcState,
    input  wire logic [steer_pkg::FREE_W-1:0]         partnerFree,
    input  wire logic [31:0]                          wmark,
    input  wire logic [1:0]                           prio,
    output logic                                      eligible
);
    logic [steer_pkg::WM_W-1:0] limit;

    always_comb begin
        case (prio)
            2'h3:    limit = '0;
            2'h2:    limit = wmark[steer_pkg::WM_HIGH_LSB +: steer_pkg::WM_W];
            2'h1:    limit = wmark[steer_pkg::WM_MED_LSB +: steer_pkg::WM_W];
            default: limit = wmark[steer_pkg::WM_LOW_LSB +: steer_pkg::WM_W];
        endcase
        case (fcState)
            steer_pkg::FC_TRANSMITTER: eligible = partnerFree > limit;
            steer_pkg::FC_RECEIVER:    eligible = 1'b1;
            default:                   eligible = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ==== logic/port_router.sv ====
// Steering of a packet class to its user-side port and packet format
`timescale 1ns/10ps
`default_nettype none
module port_router (
    input  wire logic [31:0]           ctrl,
    input  wire steer_pkg::pkt_class_e pktClass,
    input  wire logic                  incoming,
    output var  steer_pkg::port_sel_e  portSel,
    output logic                       rawFormat
);
    logic ioInitTarg;
    logic userEn;
    steer_pkg::msg_style_e   msgStyle;
    steer_pkg::maint_style_e maintStyle;

    assign ioInitTarg = ctrl[steer_pkg::IO_INITTARG_BIT];
    assign userEn     = ctrl[steer_pkg::USER_EN_BIT];
    assign msgStyle   = steer_pkg::msg_style_e'(ctrl[steer_pkg::MSG_STYLE_LSB +: 2]);
    assign maintStyle = steer_pkg::maint_style_e'(ctrl[steer_pkg::MAINT_STYLE_LSB +: 2]);

    always_comb begin
        portSel   = steer_pkg::PORT_NONE;
        rawFormat = ctrl[steer_pkg::IO_RAW_BIT];
        case (pktClass)
            steer_pkg::CLASS_IO_REQ: begin
                if (!ioInitTarg) begin
                    portSel = incoming ? steer_pkg::PORT_IO_RX : steer_pkg::PORT_IO_TX;
                end else begin
                    portSel = incoming ? steer_pkg::PORT_TARGET : steer_pkg::PORT_INITIATOR;
                end
            end
            steer_pkg::CLASS_IO_RESP: begin
                if (!ioInitTarg) begin
                    portSel = incoming ? steer_pkg::PORT_IO_RX : steer_pkg::PORT_IO_TX;
                end else begin
                    portSel = incoming ? steer_pkg::PORT_INITIATOR : steer_pkg::PORT_TARGET;
                end
            end
            steer_pkg::CLASS_MSG: begin
                case (msgStyle)
                    steer_pkg::MSG_SEPARATE: begin
                        portSel   = incoming ? steer_pkg::PORT_MSG_TARG : steer_pkg::PORT_MSG_INIT;
                        rawFormat = ctrl[steer_pkg::MSG_RAW_BIT];
                    end
                    steer_pkg::MSG_WITH_USER: begin
                        portSel   = userEn ? steer_pkg::PORT_USER : steer_pkg::PORT_NONE;
                        rawFormat = 1'b1;
                    end
                    default: begin
                        // Same lane as an I/O write request, I/O format kept
                        if (!ioInitTarg) begin
                            portSel = incoming ? steer_pkg::PORT_IO_RX : steer_pkg::PORT_IO_TX;
                        end else begin
                            portSel = incoming ? steer_pkg::PORT_TARGET : steer_pkg::PORT_INITIATOR;
                        end
                    end
                endcase
            end
            steer_pkg::CLASS_MAINT: begin
                rawFormat = 1'b0;
                if (!ctrl[steer_pkg::SRC_MAINT_BIT]) begin
                    portSel = incoming ? steer_pkg::PORT_CFG_MASTER : steer_pkg::PORT_NONE;
                end else if (maintStyle == steer_pkg::MAINT_STREAM) begin
                    portSel   = steer_pkg::PORT_MAINT_STREAM;
                    rawFormat = ctrl[steer_pkg::MAINT_RAW_BIT];
                end else if (maintStyle == steer_pkg::MAINT_WITH_USER && userEn) begin
                    portSel   = steer_pkg::PORT_USER;
                    rawFormat = 1'b1;
                end else begin
                    portSel = steer_pkg::PORT_MAINT_LITE;
                end
            end
            steer_pkg::CLASS_USER: begin
                portSel   = userEn ? steer_pkg::PORT_USER : steer_pkg::PORT_NONE;
                rawFormat = 1'b1;
            end
            default: begin
                portSel = steer_pkg::PORT_NONE;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== logic/port_steering_tx_buffer.sv ====
// Transmit buffer with response precedence, priority reordering and watermark flow control
`timescale 1ns/10ps
`default_nettype none
module port_steering_tx_buffer #(
    parameter int DATA_W   = 32,
    parameter int TX_DEPTH = 32,
    parameter int RX_DEPTH = 32
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    // APB slave
    input  wire logic [steer_pkg::APB_ADDR_W-1:0]    paddr,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [31:0]                         pwdata,
    input  wire logic [3:0]                          pstrb,
    output logic [31:0]                              prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // User transmit stream, one beat per packet
    input  wire logic                                txUserValid,
    output logic                                     txUserReady,
    input  wire logic [DATA_W-1:0]                   txUserData,
    input  wire logic [1:0]                          txUserPrio,
    input  wire logic                                txUserResp,
    input  wire steer_pkg::pkt_class_e               txUserClass,
    // Toward the physical layer
    output logic                                     linkTxValid,
    input  wire logic                                linkTxReady,
    output logic [DATA_W-1:0]                        linkTxData,
    output logic [1:0]                               linkTxPrio,
    output logic                                     linkTxRaw,
    output var  steer_pkg::port_sel_e                linkTxPort,
    input  wire logic                                linkUp,
    input  wire logic                                partnerTxFc,
    input  wire logic                                bufStatusValid,
    input  wire logic [steer_pkg::FREE_W-1:0]        bufStatusFree,
    // Receive-side steering decision
    input  wire logic                                rxClassValid,
    input  wire steer_pkg::pkt_class_e               rxClass,
    output logic                                     rxSteerValid,
    output var  steer_pkg::port_sel_e                rxPortSel,
    output logic                                     rxRaw,
    output logic                                     unifiedClock
);
    // Depths are meant to be 8, 16 or 32; the queue is sized straight from TX_DEPTH
    localparam int CNT_W = $clog2(TX_DEPTH + 1);
    localparam int IDX_W = $clog2(TX_DEPTH);

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0]        prio;
        logic              resp;
        logic              raw;
        logic [3:0]        port;
    } entry_s;

    typedef struct packed {
        entry_s [TX_DEPTH-1:0]       q;
        logic [CNT_W-1:0]            count;
        logic                        inReady;
        logic                        outValid;
        entry_s                      out;
        steer_pkg::fc_state_e        fcState;
        logic [steer_pkg::FREE_W-1:0] partnerFree;
        logic [31:0]                 ctrl;
        logic [31:0]                 wmark;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        rxValid;
        logic [3:0]                  rxPort;
        logic                        rxRaw;
    } state_s;

    state_s stateReg;
    state_s stateNext;

    logic [IDX_W-1:0]     sel;
    logic                 found;
    logic [2:0]           bestRank;
    logic                 eligible;
    logic                 launch;
    logic                 push;
    logic [CNT_W-1:0]     pushIdx;
    steer_pkg::port_sel_e txPortSel;
    logic                 txRawSel;
    steer_pkg::port_sel_e rxPortComb;
    logic                 rxRawComb;
    logic                 mapped;

    function automatic logic [31:0] mergeLanes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Responses outrank every request; priority counts only with reordering on
    function automatic logic [2:0] rankOf(
        input entry_s e,
        input logic   reorder
    );
        logic [2:0] rank;
        rank = '0;
        if (e.resp) begin
            rank = steer_pkg::RANK_RESPONSE;
        end else if (reorder) begin
            rank = {1'b0, e.prio};
        end
        return rank;
    endfunction

    port_router txRouter (
        .ctrl      (stateReg.ctrl),
        .pktClass  (txUserClass),
        .incoming  (1'b0),
        .portSel   (txPortSel),
        .rawFormat (txRawSel)
    );

    port_router rxRouter (
        .ctrl      (stateReg.ctrl),
        .pktClass  (rxClass),
        .incoming  (1'b1),
        .portSel   (rxPortComb),
        .rawFormat (rxRawComb)
    );

    fc_gate gate (
        .fcState     (stateReg.fcState),
        .partnerFree (stateReg.partnerFree),
        .wmark       (stateReg.wmark),
        .prio        (stateReg.q[sel].prio),
        .eligible    (eligible)
    );

    always_comb begin
        logic [2:0]  rank;
        logic [31:0] readVal;
        rank      = '0;
        readVal   = '0;
        stateNext = stateReg;

        // Pick the oldest entry of the highest rank; strict compare keeps age order
        sel      = '0;
        found    = 1'b0;
        bestRank = '0;
        for (int i = 0; i < TX_DEPTH; i++) begin
            if (CNT_W'(i) < stateReg.count) begin
                rank = rankOf(stateReg.q[i], stateReg.ctrl[steer_pkg::REORDER_BIT]);
                if (!found || rank > bestRank) begin
                    found    = 1'b1;
                    bestRank = rank;
                    sel      = IDX_W'(i);
                end
            end
        end

        // Eligibility is taken afresh each cycle, just before a packet starts
        launch = found && eligible && linkUp && (!stateReg.outValid || linkTxReady);
        push   = txUserValid && stateReg.inReady;

        if (stateReg.outValid && linkTxReady) begin
            stateNext.outValid = 1'b0;
        end
        if (launch) begin
            stateNext.outValid = 1'b1;
            stateNext.out      = stateReg.q[sel];
            if (stateReg.fcState == steer_pkg::FC_TRANSMITTER && stateReg.partnerFree != '0) begin
                stateNext.partnerFree = stateReg.partnerFree - 1'b1;
            end
        end
        // Fresh buffer status overrides the local estimate
        if (bufStatusValid) begin
            stateNext.partnerFree = bufStatusFree;
        end

        // Close the gap left by the departing entry, then append
        for (int i = 0; i < TX_DEPTH - 1; i++) begin
            if (launch && IDX_W'(i) >= sel) begin
                stateNext.q[i] = stateReg.q[i+1];
            end
        end
        pushIdx = stateReg.count - CNT_W'(launch);
        if (push) begin
            stateNext.q[pushIdx[IDX_W-1:0]].data = txUserData;
            stateNext.q[pushIdx[IDX_W-1:0]].prio = txUserPrio;
            stateNext.q[pushIdx[IDX_W-1:0]].resp = txUserResp;
            stateNext.q[pushIdx[IDX_W-1:0]].raw  = txRawSel;
            stateNext.q[pushIdx[IDX_W-1:0]].port = txPortSel;
        end
        stateNext.count   = stateReg.count + CNT_W'(push) - CNT_W'(launch);
        stateNext.inReady = stateNext.count < CNT_W'(TX_DEPTH);

        // Flow control mode follows the link and what the partner offers
        case (stateReg.fcState)
            steer_pkg::FC_INIT: begin
                if (linkUp) begin
                    if (stateReg.ctrl[steer_pkg::TXFC_BIT] && partnerTxFc) begin
                        stateNext.fcState = steer_pkg::FC_TRANSMITTER;
                    end else begin
                        stateNext.fcState = steer_pkg::FC_RECEIVER;
                    end
                end
            end
            steer_pkg::FC_TRANSMITTER: begin
                if (!linkUp) begin
                    stateNext.fcState = steer_pkg::FC_INIT;
                end else if (!partnerTxFc) begin
                    stateNext.fcState = steer_pkg::FC_RECEIVER;
                end
            end
            steer_pkg::FC_RECEIVER: begin
                if (!linkUp) begin
                    stateNext.fcState = steer_pkg::FC_INIT;
                end
            end
            default: begin
                stateNext.fcState = steer_pkg::FC_INIT;
            end
        endcase

        // Receive steering decision, one cycle behind its request
        stateNext.rxValid = rxClassValid;
        stateNext.rxPort  = rxPortComb;
        stateNext.rxRaw   = rxRawComb;

        // APB: one wait state, then pready for a single cycle
        mapped = paddr == steer_pkg::CTRL_OFFSET || paddr == steer_pkg::WMARK_OFFSET
              || paddr == steer_pkg::STATUS_OFFSET || paddr == steer_pkg::CAPACITY_OFFSET;
        case (paddr)
            steer_pkg::CTRL_OFFSET:   readVal = stateReg.ctrl;
            steer_pkg::WMARK_OFFSET:  readVal = stateReg.wmark;
            steer_pkg::STATUS_OFFSET: begin
                readVal[steer_pkg::FC_STATE_LSB +: 2]            = stateReg.fcState;
                readVal[steer_pkg::OCC_LSB +: CNT_W]             = stateReg.count;
                readVal[steer_pkg::FREE_LSB +: steer_pkg::FREE_W] = stateReg.partnerFree;
                readVal[steer_pkg::STAT_UNIF_BIT]                = stateReg.ctrl[steer_pkg::UNIFIED_BIT];
            end
            steer_pkg::CAPACITY_OFFSET: begin
                readVal[steer_pkg::TX_CAP_LSB +: 8] = 8'(TX_DEPTH);
                readVal[steer_pkg::RX_CAP_LSB +: 8] = 8'(RX_DEPTH);
            end
            default: readVal = '0;
        endcase
        stateNext.pready  = psel && penable && !stateReg.pready;
        stateNext.pslverr = psel && penable && !stateReg.pready && !mapped;
        stateNext.prdata  = (psel && penable && !stateReg.pready && !pwrite) ? readVal : '0;
        if (psel && penable && stateReg.pready && pwrite) begin
            if (paddr == steer_pkg::CTRL_OFFSET) begin
                stateNext.ctrl = mergeLanes(stateReg.ctrl, pwdata, pstrb);
            end
            if (paddr == steer_pkg::WMARK_OFFSET) begin
                // Ordering of the three watermarks is left to software
                stateNext.wmark = mergeLanes(stateReg.wmark, pwdata, pstrb);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateReg             <= '0;
            stateReg.ctrl        <= steer_pkg::CTRL_RESET;
            stateReg.wmark       <= steer_pkg::WMARK_RESET;
            stateReg.fcState     <= steer_pkg::FC_INIT;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign prdata       = stateReg.prdata;
    assign pready       = stateReg.pready;
    assign pslverr      = stateReg.pslverr;
    assign txUserReady  = stateReg.inReady;
    assign linkTxValid  = stateReg.outValid;
    assign linkTxData   = stateReg.out.data;
    assign linkTxPrio   = stateReg.out.prio;
    assign linkTxRaw    = stateReg.out.raw;
    assign linkTxPort   = steer_pkg::port_sel_e'(stateReg.out.port);
    assign rxSteerValid = stateReg.rxValid;
    assign rxPortSel    = steer_pkg::port_sel_e'(stateReg.rxPort);
    assign rxRaw        = stateReg.rxRaw;
    // One clock domain only; the flag tells the user both layer clocks must be tied
    assign unifiedClock = stateReg.ctrl[steer_pkg::UNIFIED_BIT];
endmodule
`default_nettype wire

// ==== testbench/phy_sink.sv ====
// Physical-layer sink accepting link packets with random stalls
`timescale 1ns/10ps
`default_nettype none
module phy_sink (
    input wire logic ref_clk,
    input wire logic rst,
    output var logic linkTxReady
);
    // Stalls three edges in four at random, so held packets are exercised
    always_ff @(posedge ref_clk) begin
        linkTxReady <= !rst && ($urandom_range(3, 0) == 0);
    end
endmodule
`default_nettype wire

// ==== testbench/port_steering_tx_buffer_monitor.sv ====
// Port-level checker for the transmit buffer
`timescale 1ns/10ps
`default_nettype none
module port_steering_tx_buffer_monitor #(
    parameter int DATA_W = 32
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              txUserReady,
    input wire logic              linkTxValid,
    input wire logic              linkTxReady,
    input wire logic [DATA_W-1:0] linkTxData,
    input wire logic [1:0]        linkTxPrio,
    input wire logic              linkUp,
    input wire logic              rxClassValid,
    input wire logic              rxSteerValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_apb_answer: assert property (psel && penable && !pready |=> pready) else $error("no pready after access");
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_pready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_link_hold: assert property (linkTxValid && !linkTxReady |=>
        linkTxValid && $stable(linkTxData) && $stable(linkTxPrio)) else $error("link packet changed");
    a_send_up: assert property ($rose(linkTxValid) |-> $past(linkUp)) else $error("sent with link down");
    a_steer_delay: assert property (rxClassValid |=> rxSteerValid) else $error("no steer answer");
    a_steer_only: assert property (!rxClassValid |=> !rxSteerValid) else $error("steer without request");
    a_ready_up: assert property ($fell(rst) |-> ##[1:2] txUserReady) else $error("no room after reset");
endmodule
`default_nettype wire

// ==== testbench/tb_port_steering_tx_buffer_flow_ctrl.sv ====
// Self-checking bench for the port steering transmit buffer
`timescale 1ns/10ps
`default_nettype none
module tb_port_steering_tx_buffer_flow_ctrl;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, txUserValid = 0, txUserResp = 0, er;
    logic        linkUp = 0, partnerTxFc = 0, bufStatusValid = 0, rxClassValid = 0, pready, pslverr, txUserReady;
    logic        linkTxValid, linkTxReady, linkTxRaw, rxSteerValid, rxRaw, unifiedClock;
    logic [7:0]  paddr = 0, bufStatusFree = 0;
    logic [31:0] pwdata = 0, txUserData = 0, prdata, rd, linkTxData, dat[16], q[$];
    logic [3:0]  pstrb = 4'hF;
    logic [1:0]  txUserPrio = 0, linkTxPrio;
    steer_pkg::pkt_class_e txUserClass = steer_pkg::CLASS_IO_REQ, rxClass = steer_pkg::CLASS_IO_REQ, pc;
    steer_pkg::port_sel_e  linkTxPort, rxPortSel;
    int          error_cnt = 0, num_checks = 0;
    port_steering_tx_buffer #(.TX_DEPTH(8), .RX_DEPTH(16)) i_dut (.ref_clk, .rst, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .txUserValid, .txUserReady, .txUserData, .txUserPrio,
        .txUserResp, .txUserClass, .linkTxValid, .linkTxReady, .linkTxData, .linkTxPrio, .linkTxRaw, .linkTxPort,
        .linkUp, .partnerTxFc, .bufStatusValid, .bufStatusFree, .rxClassValid, .rxClass, .rxSteerValid, .rxPortSel,
        .rxRaw, .unifiedClock);
    phy_sink i_phy (.ref_clk, .rst, .linkTxReady);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic put(int i, logic [1:0] p, bit r);
        @(posedge ref_clk);
        dat[i] = {1'b0, r ? steer_pkg::PORT_TARGET : steer_pkg::PORT_INITIATOR, p, 25'($urandom)};
        {txUserValid, txUserData, txUserPrio, txUserResp} <= {1'b1, dat[i], p, r};
        txUserClass <= r ? steer_pkg::CLASS_IO_RESP : steer_pkg::CLASS_IO_REQ;
        do @(posedge ref_clk); while (txUserReady !== 1'b1);
        txUserValid <= 0;
    endtask
    task automatic load(logic [7:0] f);
        @(posedge ref_clk);
        {bufStatusValid, bufStatusFree} <= {1'b1, f};
        @(posedge ref_clk);
        bufStatusValid <= 0;
    endtask
    // Blocked packets must leave the link idle once the expected ones are out
    task automatic drain;
        repeat (300) if (q.size() != 0) @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        chk("pending", 0, q.size());
        chk("linkTxValid", 0, linkTxValid);
    endtask
    always @(posedge ref_clk) begin
        rxClassValid <= 1'($urandom_range(1, 0));
        rxClass <= steer_pkg::pkt_class_e'($urandom_range(4, 0));
        if (linkTxValid === 1'b1 && linkTxReady === 1'b1)
            chk("linkTx", q.pop_front(), {linkTxRaw, linkTxPort, linkTxPrio, linkTxData[24:0]});
        if (rxSteerValid === 1'b1 && pc == steer_pkg::CLASS_USER)
            chk("rxPortSel", {1'b1, steer_pkg::PORT_USER}, {rxRaw, rxPortSel});
        pc = rxClass;
    end
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(32'h520F));
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        apb(0, steer_pkg::CTRL_OFFSET, 0);
        chk("ctrl", steer_pkg::CTRL_RESET, rd);
        chk("unifiedClock", 1, unifiedClock);
        apb(0, steer_pkg::WMARK_OFFSET, 0);
        chk("wmark", 32'h0003_0201, rd);
        apb(1, steer_pkg::WMARK_OFFSET, 32'h0003_0201);
        apb(0, steer_pkg::CAPACITY_OFFSET, 0);
        chk("capacity", 32'h0000_1008, rd);
        apb(0, 8'h10, 0);
        chk("pslverr", 1, er);
        put(1, 0, 0);
        put(2, 2, 0);
        put(3, 1, 1);
        linkUp <= 1;
        q.push_back(dat[3]);
        q.push_back(dat[2]);
        q.push_back(dat[1]);
        drain();
        linkUp <= 0;
        apb(1, steer_pkg::CTRL_OFFSET, steer_pkg::CTRL_RESET & 32'hFFFF_FFFE);
        put(4, 0, 0);
        put(5, 2, 0);
        linkUp <= 1;
        q.push_back(dat[4]);
        q.push_back(dat[5]);
        drain();
        linkUp <= 0;
        partnerTxFc <= 1;
        put(6, 3, 0);
        put(7, 3, 0);
        put(8, 0, 0);
        linkUp <= 1;
        q.push_back(dat[6]);
        load(1);
        drain();
        q.push_back(dat[7]);
        load(4);
        drain();
        q.push_back(dat[8]);
        load(4);
        drain();
        conclude();
    end
endmodule
bind port_steering_tx_buffer port_steering_tx_buffer_monitor #(.DATA_W(DATA_W)) i_mon (.ref_clk, .rst, .psel,
    .penable, .pready, .pslverr, .txUserReady, .linkTxValid, .linkTxReady, .linkTxData, .linkTxPrio, .linkUp,
    .rxClassValid, .rxSteerValid);
`default_nettype wire
